// ---- include/stop_ctrl_pkg.sv ----
// Purpose: constants and types for the stop mode controller
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes:   register offsets are byte addresses
package stop_ctrl_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] system_options_1_off  = 8'h00;
   localparam logic [7:0] power_mgmt_ctrl_1_off = 8'h04;
   localparam logic [7:0] power_mgmt_ctrl_2_off = 8'h08;
   localparam logic [7:0] clock_src_ctrl_off    = 8'h0c;
   localparam logic [7:0] status_off            = 8'h10;
   // field positions
   localparam int stop_enable_bit       = 0;
   localparam int lv_detect_enable_bit  = 0;
   localparam int lv_stop_enable_bit    = 1;
   localparam int pp_select_bit         = 0;
   localparam int pp_flag_bit           = 1;
   localparam int pp_ack_bit            = 2;
   localparam int int_ref_bit           = 0;
   localparam int ext_ref_bit           = 1;
   localparam int hf_range_bit          = 2;
   localparam int rtc_wake_enable_bit   = 3;
   // reset values
   localparam logic system_options_1_rst = 1'b1;
   localparam logic [1:0] power_mgmt_1_rst = 2'h1;
   localparam logic [3:0] clock_src_rst  = 4'h0;
   // reset pulse length in cycles
   localparam logic [3:0] reset_pulse_cycles = 4'h4;

   typedef enum logic [1:0] {
      st_run     = 2'b00,
      st_shallow = 2'b01,
      st_deep    = 2'b10,
      st_bgnd    = 2'b11
   } stop_state_t;
endpackage

// ---- rtl/stop_mode_controller.sv ----
// Purpose: stop mode entry, depth choice, clock gating and wakeup
// Assumes: one clock pclk, 20 MHz; pin inputs raw and synchronised here
// Notes:   apb registers; debug enable only via debug port
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module stop_mode_controller
   import stop_ctrl_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        stop_instr,
   input  wire logic        reset_pin_enable,
   input  wire logic        reset_pin_n,
   input  wire logic        wake_irq,
   input  wire logic        rtc_wake,
   input  wire logic        dbg_wr_enable,
   input  wire logic        dbg_wr_value,
   input  wire logic        dbg_status_access,
   input  wire logic        debug_halt_command,
   input  wire logic        dbg_go,
   output logic             debug_mode_enable,
   output logic             dbg_status_error,
   output logic             illegal_opcode_reset,
   output logic             system_reset,
   output logic             fetch_reset_vector,
   output logic             fetch_irq_vector,
   output logic             bus_clk_en,
   output logic             cpu_clk_en,
   output logic             periph_clk_en,
   output logic             debug_clk_en,
   output logic             regulator_full,
   output logic             int_ref_run,
   output logic             ext_ref_run,
   output logic             core_power_on,
   output logic             pin_latch_closed,
   output logic             in_stop
);

   // ==========================================
   // synchronisers for outside pins
   logic [1:0] rst_pin_sync;
   logic [1:0] irq_sync;
   logic [1:0] rtc_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_pin_sync <= 2'h3;
         irq_sync     <= 2'h0;
         rtc_sync     <= 2'h0;
      end else begin
         rst_pin_sync <= {rst_pin_sync[0], reset_pin_n};
         irq_sync     <= {irq_sync[0], wake_irq};
         rtc_sync     <= {rtc_sync[0], rtc_wake};
      end
   end
   logic pin_low;
   logic irq_in;
   logic rtc_in;
   assign pin_low = !rst_pin_sync[1];
   assign irq_in  = irq_sync[1];
   assign rtc_in  = rtc_sync[1];

   // ==========================================
   // registers
   stop_state_t state;
   stop_state_t next_state;
   logic       stop_enable;
   logic       lv_detect_en;
   logic       lv_stop_en;
   logic       pp_select;
   logic       pp_flag;
   logic [3:0] clk_src;
   logic       soft_reset;
   logic       wr_en;
   logic       deep_wake;
   assign wr_en = psel && penable && pwrite;

   // registers reset on any system reset, incl. deep wakeup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_enable  <= system_options_1_rst;
         lv_detect_en <= power_mgmt_1_rst[0];
         lv_stop_en   <= power_mgmt_1_rst[1];
         pp_select    <= 1'b0;
         clk_src      <= clock_src_rst;
      end else if (soft_reset) begin
         stop_enable  <= system_options_1_rst;
         lv_detect_en <= 1'b1; // lv reset enabled, low trip
         lv_stop_en   <= power_mgmt_1_rst[1];
         pp_select    <= 1'b0;
         clk_src      <= clock_src_rst;
      end else if (wr_en) begin
         case (paddr)
            system_options_1_off: stop_enable <= pwdata[stop_enable_bit];
            power_mgmt_ctrl_1_off: begin
               lv_detect_en <= pwdata[lv_detect_enable_bit];
               lv_stop_en   <= pwdata[lv_stop_enable_bit];
            end
            power_mgmt_ctrl_2_off: pp_select <= pwdata[pp_select_bit];
            clock_src_ctrl_off: clk_src <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // flag survives the wakeup reset; set wins over ack
   logic ack_wr;
   // an ack during the internal reset is dropped like any other write
   assign ack_wr = wr_en && !soft_reset && paddr == power_mgmt_ctrl_2_off && pwdata[pp_ack_bit];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pp_flag <= 1'b0;
      end else if (deep_wake) begin
         pp_flag <= 1'b1;
      end else if (ack_wr) begin
         pp_flag <= 1'b0;
      end
   end

   // debug enable only through the debug port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         debug_mode_enable <= 1'b0;
      end else if (dbg_wr_enable) begin
         debug_mode_enable <= dbg_wr_value;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            system_options_1_off:  prdata <= {31'h0, stop_enable};
            power_mgmt_ctrl_1_off: prdata <= {30'h0, lv_stop_en, lv_detect_en};
            power_mgmt_ctrl_2_off: prdata <= {29'h0, 1'b0, pp_flag, pp_select};
            clock_src_ctrl_off:    prdata <= {28'h0, clk_src};
            status_off:            prdata <= {28'h0, pin_latch_closed, in_stop, state};
            default:               prdata <= 32'h0;
         endcase
      end
   end
   logic mapped;
   assign mapped = paddr == system_options_1_off || paddr == power_mgmt_ctrl_1_off ||
                   paddr == power_mgmt_ctrl_2_off || paddr == clock_src_ctrl_off ||
                   paddr == status_off;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ==========================================
   // stop state machine
   logic want_deep;
   logic pin_wake;
   logic lv_both;
   logic lv_both_at_entry;
   logic dbg_at_entry;
   assign lv_both  = lv_detect_en && lv_stop_en;
   // deep only without debug and lv-stop
   assign want_deep = pp_select && !debug_mode_enable && !lv_stop_en;
   assign pin_wake  = pin_low && reset_pin_enable;

   always_comb begin
      next_state = state;
      case (state)
         st_run: begin
            if (stop_instr && stop_enable) begin
               next_state = want_deep ? st_deep : st_shallow;
            end
         end
         st_shallow: begin
            if (debug_halt_command && debug_mode_enable) begin
               next_state = st_bgnd;
            end else if (pin_wake || irq_in || rtc_in) begin
               next_state = st_run;
            end
         end
         st_deep: begin
            if (pin_low || (rtc_in && clk_src[rtc_wake_enable_bit])) begin
               next_state = st_run;
            end
         end
         st_bgnd: begin
            if (dbg_go) begin
               next_state = st_run;
            end
         end
         default: next_state = st_run;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_run;
      end else begin
         state <= next_state;
      end
   end

   // entry snapshot of lv and debug bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lv_both_at_entry <= 1'b0;
         dbg_at_entry     <= 1'b0;
      end else if (state == st_run && stop_instr && stop_enable) begin
         lv_both_at_entry <= lv_both;
         dbg_at_entry     <= debug_mode_enable;
      end
   end

   // ==========================================
   // resets and vectors
   logic [3:0] rst_cnt;
   logic       pin_exit;
   logic       irq_exit;
   logic       illegal;
   assign illegal   = state == st_run && stop_instr && !stop_enable;
   assign deep_wake = state == st_deep && next_state == st_run;
   assign pin_exit  = state == st_shallow && next_state == st_run && pin_wake;
   assign irq_exit  = state == st_shallow && next_state == st_run && !pin_wake;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt <= 4'h0;
      end else if (illegal || deep_wake || pin_exit) begin
         rst_cnt <= reset_pulse_cycles;
      end else if (rst_cnt != 4'h0) begin
         rst_cnt <= rst_cnt - 4'h1;
      end
   end
   assign soft_reset = rst_cnt != 4'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         illegal_opcode_reset <= 1'b0;
         fetch_reset_vector   <= 1'b0;
         fetch_irq_vector     <= 1'b0;
      end else begin
         illegal_opcode_reset <= illegal;
         fetch_reset_vector   <= rst_cnt == 4'h1;
         fetch_irq_vector     <= irq_exit;
      end
   end
   assign system_reset = soft_reset;

   // latches held closed from deep entry until ack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_latch_closed <= 1'b0;
      end else if (next_state == st_deep) begin
         pin_latch_closed <= 1'b1;
      end else if (ack_wr && !deep_wake) begin
         pin_latch_closed <= 1'b0;
      end
   end

   // ==========================================
   // clocks and power
   logic stopped;
   assign stopped  = state == st_shallow || state == st_deep;
   assign in_stop  = stopped;
   assign bus_clk_en    = !stopped;
   assign cpu_clk_en    = !stopped;
   assign periph_clk_en = !stopped;
   assign debug_clk_en  = state != st_deep && (!stopped || dbg_at_entry);
   // shallow stop keeps the core powered, state is held
   assign core_power_on = state != st_deep;
   assign regulator_full = !stopped ||
                           (state == st_shallow && (lv_both_at_entry || dbg_at_entry));
   assign int_ref_run = !stopped || (state == st_shallow && clk_src[int_ref_bit]);
   // high range needs the lv detector alive in stop, i.e. both lv bits
   assign ext_ref_run = !stopped || (state == st_shallow && clk_src[ext_ref_bit] &&
                        (!clk_src[hf_range_bit] || lv_both_at_entry));
   // status access refused while stopped
   assign dbg_status_error = dbg_status_access && stopped;

   // ==========================================
   // assertions
   AST_ILLEGAL: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_run && stop_instr && !stop_enable) |=> illegal_opcode_reset && state == st_run)
      else $error("stop while disabled did not reset");
   AST_DEPTH: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_run && stop_instr && stop_enable && !pp_select) |=> state == st_shallow)
      else $error("shallow stop not entered");
   AST_DEEP_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_run && stop_instr && stop_enable && (debug_mode_enable || lv_stop_en))
      |=> state != st_deep)
      else $error("deep stop entered with debug or lv stop");
   AST_CLKS: assert property (@(posedge pclk) disable iff (!presetn)
      stopped |-> !bus_clk_en && !cpu_clk_en && !periph_clk_en)
      else $error("clock running in stop");
   AST_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      deep_wake |=> pp_flag && pin_latch_closed && system_reset)
      else $error("deep wakeup did not set flag");
   AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(pp_flag) && !pp_flag) |-> $past(ack_wr))
      else $error("flag cleared without ack");
   AST_DBG_ERR: assert property (@(posedge pclk) disable iff (!presetn)
      (stopped && dbg_status_access) |-> dbg_status_error)
      else $error("status access in stop not refused");
   AST_RST_VEC: assert property (@(posedge pclk) disable iff (!presetn)
      pin_exit |=> ##4 fetch_reset_vector)
      else $error("reset vector not fetched after pin exit");
   AST_BGND: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_shallow && debug_halt_command && debug_mode_enable) |=> state == st_bgnd)
      else $error("halt command did not wake");
   AST_SHALLOW_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_shallow && !debug_halt_command && (irq_in || rtc_in || pin_wake))
      |=> state == st_run)
      else $error("shallow stop not left on wakeup");
   AST_IRQ_VEC: assert property (@(posedge pclk) disable iff (!presetn)
      irq_exit |=> fetch_irq_vector && state == st_run)
      else $error("interrupt vector not fetched after exit");
   AST_REG_LV: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_shallow && lv_both_at_entry) |-> regulator_full)
      else $error("regulator not kept active with lv in stop");
   AST_DBG_CLK: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_shallow && dbg_at_entry) |-> debug_clk_en && regulator_full)
      else $error("debug clocks or regulation lost in stop");
   AST_DEEP_PWR: assert property (@(posedge pclk) disable iff (!presetn)
      state == st_deep |-> !core_power_on && pin_latch_closed)
      else $error("deep stop powered or pins unlatched");
   AST_DEEP_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_deep && pin_low) |=> state == st_run && system_reset)
      else $error("wakeup pin did not leave deep stop");
   AST_LATCH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(pin_latch_closed) && !pin_latch_closed) |-> $past(ack_wr))
      else $error("pin latches opened without ack");
   AST_EXT_REF: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_shallow && clk_src[hf_range_bit] && !lv_both_at_entry) |-> !ext_ref_run)
      else $error("high range reference kept without lv detect");
   COV_SHALLOW: cover property (@(posedge pclk) disable iff (!presetn)
      state == st_shallow ##1 state == st_run);
   COV_DEEP: cover property (@(posedge pclk) disable iff (!presetn) deep_wake);
   COV_ILLEGAL: cover property (@(posedge pclk) disable iff (!presetn) illegal);
   COV_BGND: cover property (@(posedge pclk) disable iff (!presetn)
      state == st_shallow ##1 state == st_bgnd);
   COV_PIN_EXIT: cover property (@(posedge pclk) disable iff (!presetn) pin_exit);
endmodule

// ---- test/stop_partner_model.sv ----
// Purpose: cpu core and wakeup sources facing the stop controller
// Assumes: bench commands arrive as levels on the req inputs
// Notes:   a halted cpu cannot issue stop, so stop waits for its clock
`timescale 1ns/1ps
module stop_partner_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic bus_clk_en,
   input  wire logic [3:0] req_v,
   output logic      stop_instr,
   output logic      wake_irq,
   output logic      rtc_wake,
   output logic      reset_pin_n
);
   // ==========================================
   // cpu: stop issued only while clocked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_instr <= 1'b0;
      end else begin
         stop_instr <= req_v[0] && bus_clk_en;
      end
   end
   // ==========================================
   // wake sources: levels held as long as asked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_irq    <= 1'b0;
         rtc_wake    <= 1'b0;
         reset_pin_n <= 1'b1;
      end else begin
         wake_irq    <= req_v[1];
         rtc_wake    <= req_v[2];
         reset_pin_n <= !req_v[3];
      end
   end
endmodule

// ---- test/tb_stop_mode_controller.sv ----
// Purpose: self-checking bench for the stop mode controller
// Assumes: 20 MHz pclk, apb master, partner model for cpu and wake sources
// Notes:   random depth settings with fixed corner cases first
`timescale 1ns/1ps
module tb_stop_mode_controller import stop_ctrl_pkg::*; ();
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rq, r;
   logic        re, dbg, low_voltage_detector, lvs, pps, deep;
   logic [3:0]  req_v;
   logic        stop_instr, reset_pin_enable, reset_pin_n, wake_irq, rtc_wake;
   logic        dbg_wr_enable, dbg_wr_value, dbg_status_access, debug_halt_command, dbg_go;
   logic        debug_mode_enable, dbg_status_error, illegal_opcode_reset, system_reset;
   logic        fetch_reset_vector, fetch_irq_vector, bus_clk_en, cpu_clk_en;
   logic        periph_clk_en, debug_clk_en, regulator_full, int_ref_run, ext_ref_run;
   logic        core_power_on, pin_latch_closed, in_stop;
   int          mismatches = 0, n_checks = 0, cycles = 0, i, seed;
   logic [31:0] corner [4] = '{32'h188, 32'h60c, 32'h109, 32'h066};

   always #25 pclk = ~pclk;

   stop_mode_controller i_stop_mode_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stop_instr(stop_instr),
      .reset_pin_enable(reset_pin_enable), .reset_pin_n(reset_pin_n), .wake_irq(wake_irq),
      .rtc_wake(rtc_wake), .dbg_wr_enable(dbg_wr_enable), .dbg_wr_value(dbg_wr_value),
      .dbg_status_access(dbg_status_access), .debug_halt_command(debug_halt_command),
      .dbg_go(dbg_go), .debug_mode_enable(debug_mode_enable),
      .dbg_status_error(dbg_status_error), .illegal_opcode_reset(illegal_opcode_reset),
      .system_reset(system_reset), .fetch_reset_vector(fetch_reset_vector),
      .fetch_irq_vector(fetch_irq_vector), .bus_clk_en(bus_clk_en), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .debug_clk_en(debug_clk_en),
      .regulator_full(regulator_full), .int_ref_run(int_ref_run), .ext_ref_run(ext_ref_run),
      .core_power_on(core_power_on), .pin_latch_closed(pin_latch_closed), .in_stop(in_stop));

   stop_partner_model i_stop_partner_model (.pclk(pclk), .presetn(presetn),
      .bus_clk_en(bus_clk_en), .req_v(req_v), .stop_instr(stop_instr), .wake_irq(wake_irq),
      .rtc_wake(rtc_wake), .reset_pin_n(reset_pin_n));

   // ==========================================
   // shared tasks
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // no wait count assumed: loops until pready, the bench timeout bounds it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rq      = prdata;
      re      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic sig(input int w);
      case (w)
         0: return in_stop;
         1: return system_reset;
         2: return fetch_reset_vector;
         3: return illegal_opcode_reset;
         5: return pin_latch_closed;
         default: return fetch_irq_vector;
      endcase
   endfunction

   // sampled 1 ns after each edge so single-cycle pulses are not missed
   task automatic wt(input int w, input logic v);
      int n;
      n = 0;
      while (sig(w) !== v && n < 100) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk(sig(w), v);
   endtask

   task automatic hold(input int b, input int n);
      @(posedge pclk);
      req_v[b] <= 1'b1;
      repeat (n) @(posedge pclk);
      req_v[b] <= 1'b0;
   endtask

   task automatic pulse_dbg(input int w);
      @(posedge pclk);
      if (w == 0) debug_halt_command <= 1'b1;
      else dbg_go <= 1'b1;
      @(posedge pclk);
      debug_halt_command <= 1'b0;
      dbg_go <= 1'b0;
   endtask

   always @(posedge pclk) begin
      cycles++;
      if (cycles > 30000) begin
         mismatches++;
         conclude();
      end
   end

   // ==========================================
   // main sequence
   initial begin
      seed = 77921;
      {presetn, psel, penable, pwrite, paddr, pwdata, req_v} = '0;
      {reset_pin_enable, dbg_wr_enable, dbg_wr_value} = '0;
      {dbg_status_access, debug_halt_command, dbg_go} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rq, (i < 2) ? 32'h1 : 32'h0);
      end
      apb(1'b0, 8'h14, 32'h0);
      chk(re, 1'b1);
      apb(1'b1, system_options_1_off, 32'h0);
      hold(0, 1);
      wt(3, 1'b1);
      chk(in_stop, 1'b0);
      wt(1, 1'b1);
      wt(1, 1'b0);
      apb(1'b0, system_options_1_off, 32'h0);
      chk(rq, 32'h1);
      for (i = 0; i < 24; i++) begin
         // corner 3 keeps both voltage enables for a converter in stop
         r = (i < 4) ? corner[i] : $random(seed);
         {pps, lvs, low_voltage_detector, dbg} = r[3:0];
         deep = pps && !dbg && !lvs;
         @(posedge pclk);
         dbg_wr_enable    <= 1'b1;
         dbg_wr_value     <= dbg;
         reset_pin_enable <= r[9];
         @(posedge pclk);
         dbg_wr_enable    <= 1'b0;
         apb(1'b1, system_options_1_off, 32'hffffffff);
         apb(1'b1, power_mgmt_ctrl_1_off, {30'h0, lvs, low_voltage_detector});
         apb(1'b1, power_mgmt_ctrl_2_off, {31'h0, pps});
         apb(1'b1, clock_src_ctrl_off, {28'h0, r[7:4]});
         chk(debug_mode_enable, dbg);
         hold(0, 1);
         wt(0, 1'b1);
         apb(1'b0, status_off, 32'h0);
         chk(rq, {28'h0, deep, 1'b1, deep ? 2'b10 : 2'b01});
         chk({bus_clk_en, cpu_clk_en, periph_clk_en}, 32'h0);
         chk(debug_clk_en, dbg);
         chk(regulator_full, !deep && (dbg || (low_voltage_detector && lvs)));
         chk({core_power_on, pin_latch_closed}, deep ? 2'b01 : 2'b10);
         chk(int_ref_run, !deep && r[4]);
         chk(ext_ref_run, !deep && r[5] && (!r[6] || (low_voltage_detector && lvs)));
         @(posedge pclk);
         dbg_status_access <= 1'b1;
         @(posedge pclk);
         #1 chk(dbg_status_error, 1'b1);
         @(posedge pclk);
         dbg_status_access <= 1'b0;
         if (deep) begin
            fork
               hold((r[7] && r[8]) ? 2 : 3, 4);
               wt(1, 1'b1);
            join
            wt(2, 1'b1);
            apb(1'b0, power_mgmt_ctrl_2_off, 32'h0);
            chk(rq, 32'h2);
            apb(1'b0, clock_src_ctrl_off, 32'h0);
            chk(rq, 32'h0);
            chk(pin_latch_closed, 1'b1);
            // registers read back at reset values with the flag set, latches closed, before the ack
            apb(1'b1, power_mgmt_ctrl_2_off, 32'h4);
            wt(5, 1'b0);
            apb(1'b0, power_mgmt_ctrl_2_off, 32'h0);
            chk(rq, 32'h0);
         end else begin
            apb(1'b0, power_mgmt_ctrl_1_off, 32'h0);
            chk(rq, {30'h0, lvs, low_voltage_detector});
            if (dbg && r[8]) begin
               pulse_dbg(0);
               apb(1'b0, status_off, 32'h0);
               chk(rq[1:0], 2'b11);
               pulse_dbg(1);
               apb(1'b0, status_off, 32'h0);
               chk(rq[2:0], 3'b000);
            end else if (r[9] && r[10]) begin
               fork
                  hold(3, 4);
                  wt(1, 1'b1);
               join
               wt(2, 1'b1);
            end else begin
               fork
                  hold(1, 6);
                  wt(6, 1'b1);
               join
               chk({system_reset, in_stop}, 32'h0);
            end
         end
      end
      conclude();
   end
endmodule
